// File: slam_defines.svh
`ifndef SLAM_DEFINES_SVH
`define SLAM_DEFINES_SVH
// Register byte offsets
`define SLAM_CTRL_OFF      12'h000
`define SLAM_STATUS_OFF    12'h004
`define SLAM_IRQ_STAT_OFF  12'h008
`define SLAM_IRQ_MASK_OFF  12'h00c
`define SLAM_UTIL_OFF      12'h010
`define SLAM_LED_OFF       12'h014
// Control fields
`define SLAM_CTRL_FILTER   0
`define SLAM_CTRL_SCRAM    1
`define SLAM_CTRL_LOOP     2
`define SLAM_CTRL_HCLR     3
`define SLAM_CTRL_PORTSEL  4
`define SLAM_CTRL_RST      5'h00
// Timing
`define SLAM_CLK_HZ        20000000
`define SLAM_LCD_US        4000
`define SLAM_LCD_CYC       ((`SLAM_CLK_HZ / 1000000) * `SLAM_LCD_US)
// Slicing threshold, percent of one line rate
`define SLAM_SLICE_PCT     114
// Unequipped path label
`define SLAM_C2_UNEQ       8'h00
`endif

// File: slam_ind.sv
`timescale 1ns/1ps
// One indication: current and history with clear
module slam_ind
  import slam_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      cond,
  input  wire logic      hist_clr,
  output slam_ind_e      ind
);
  logic seen_reg;   // History flag
  logic seen_next;

  // Set wins over clear so a new defect is never lost
  assign seen_next = cond | (seen_reg & ~hist_clr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seen_reg <= 1'b0;
    else
      seen_reg <= seen_next;
  end

  assign ind = cond ? SLAM_ACTIVE : (seen_reg ? SLAM_HISTORY : SLAM_CLEAN);

  chk_active_wins : assert property (@(posedge pclk) disable iff (!presetn)
    cond |=> ind != SLAM_CLEAN) else $error("Active not shown");
endmodule : slam_ind

// File: slam_lcd.sv
`timescale 1ns/1ps
`include "slam_defines.svh"
// Loss of cell delineation qualifier
module slam_lcd
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ocd,
  output logic      lcd
);
  localparam int LCD_CYC = `SLAM_LCD_CYC;
  logic [16:0] cnt_reg;   // Cycles of continuous loss

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= 17'h00000;
    else if (!ocd)
      cnt_reg <= 17'h00000;
    else if (cnt_reg != 17'(LCD_CYC))
      cnt_reg <= cnt_reg + 17'h00001;
  end

  // Declared only once full time elapsed
  assign lcd = ocd && (cnt_reg == 17'(LCD_CYC));

  chk_lcd_early : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ocd) |-> !lcd [*8]) else $error("Loss declared early");
endmodule : slam_lcd

// File: slam_line_model.sv
`timescale 1ns/1ps
// Far-end line: defect levels and framing on rx1, rx2 clean
module slam_line_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [6:0]  fault,
  input  wire logic        ones,
  output logic [1:0]       oof,
  output logic [1:0]       ocd,
  output logic [1:0]       line_rdi,
  output logic [1:0]       path_ais,
  output logic [1:0]       path_rdi,
  output logic [1:0]       lop,
  output logic [15:0]      c2_label,
  output logic [1:0]       frame_end,
  output logic [1:0]       zero_seen
);
  logic [2:0] fcnt_reg; // Frame timer
  // Frame boundary every eight clocks
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      fcnt_reg <= 3'h0;
    else
      fcnt_reg <= fcnt_reg + 3'h1;
  assign frame_end = {2{fcnt_reg == 3'h7}};
  // All-ones line sends no zeros at all
  assign zero_seen = ones ? 2'h0 : 2'h3;
  assign oof      = {1'b0, fault[0]};
  assign ocd      = {1'b0, fault[1]};
  assign line_rdi = {1'b0, fault[2]};
  assign path_ais = {1'b0, fault[3]};
  assign path_rdi = {1'b0, fault[4]};
  assign lop      = {1'b0, fault[5]};
  // Equipped label unless told otherwise
  assign c2_label = {8'h5a, fault[6] ? 8'h00 : 8'h13};
endmodule : slam_line_model

// File: slam_monitor.sv
`timescale 1ns/1ps
`include "slam_defines.svh"
//Behaviour
//- Frame sync: red OOF, orange past, green
//- Cell loss declared after 4 ms continuous
//- Cell sync: red active, orange past, green
//- Alarm combines seven line/path conditions
//- AIS: under three zeros, two frames, while OOF
//- RDI flagged on remote indication
//- C2 alarm on unequipped label
//- Lost pointer joins alarm summary
//- Out of frame joins alarm summary
//- Alarm: off, red active, orange past
//- Slicing when summed utilization exceeds 114%
//- Slicing drops some payload bytes
//- Slicing: off, red present, orange past
//- Optionally discard idle/unassigned cells
//- Scrambling only when enabled
//- Loopback routes first transmitter to second receiver
//- Restart or stats reset clears history
//- Independent indications per receiver
module slam_monitor
  import slam_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        restart,
  input  wire logic [1:0]  oof,
  input  wire logic [1:0]  ocd,
  input  wire logic [1:0]  line_rdi,
  input  wire logic [1:0]  path_ais,
  input  wire logic [1:0]  path_rdi,
  input  wire logic [1:0]  lop,
  input  wire logic [15:0] c2_label,
  input  wire logic [1:0]  frame_end,
  input  wire logic [1:0]  zero_seen,
  input  wire logic [1:0]  cell_valid,
  input  wire logic [1:0]  cell_idle,
  input  wire logic [7:0]  first_receiver_data,
  input  wire logic [7:0]  second_receiver_data,
  input  wire logic [7:0]  first_transmitter_data,
  input  wire logic        payload_byte,
  output logic [7:0]       first_receiver_out,
  output logic [7:0]       second_receiver_out,
  output logic [1:0]       cell_pass,
  output logic             byte_drop,
  output logic [13:0]      led_state,
  output logic             irq
);
  // Software state
  logic [4:0]  ctrl_reg;       // Filter, scramble, loop, hist clear, port
  logic [15:0] util_reg;       // Two 8-bit utilisation percentages
  logic [9:0]  irq_stat_reg;   // Sticky events
  logic [9:0]  irq_mask_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  // Bus decode
  wire         acc     = psel & penable;
  wire         wr_ok   = acc & pwrite;
  wire         hit_ctl = paddr == `SLAM_CTRL_OFF;
  wire         hit_st  = paddr == `SLAM_STATUS_OFF;
  wire         hit_is  = paddr == `SLAM_IRQ_STAT_OFF;
  wire         hit_im  = paddr == `SLAM_IRQ_MASK_OFF;
  wire         hit_ut  = paddr == `SLAM_UTIL_OFF;
  wire         hit_led = paddr == `SLAM_LED_OFF;
  wire         mapped  = hit_ctl | hit_st | hit_is | hit_im | hit_ut | hit_led;

  // History cleared by restart or statistics reset
  wire hist_clr = restart | (wr_ok & hit_ctl & pwdata[`SLAM_CTRL_HCLR]);

  // AIS: zeros counted over the current pair of frames
  logic [1:0] zc0_reg [2];   // Zero count, current frame
  logic [1:0] zc1_reg [2];   // Zero count, previous frame
  logic [1:0] ais_reg;
  logic [1:0] ais_cond;
  logic [1:0] c2_uneq;
  logic [1:0] alarm_any;
  logic [1:0] lcd;
  slam_ind_e  fr_ind [2];
  slam_ind_e  cs_ind [2];
  slam_ind_e  al_ind [2];
  slam_ind_e  sl_ind;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_rx
      wire [2:0] zsum = {1'b0, zc0_reg[g]} + {1'b0, zc1_reg[g]};
      // Fewer than three zeros across two frames, while out of frame
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          zc0_reg[g] <= 2'h0;
          zc1_reg[g] <= 2'h3;
          ais_reg[g] <= 1'b0;
        end
        else if (frame_end[g])
        begin
          zc1_reg[g] <= zc0_reg[g];
          zc0_reg[g] <= 2'h0;
          ais_reg[g] <= (zsum < 3'h3) & oof[g];
        end
        else if (zero_seen[g] && zc0_reg[g] != 2'h3)
          zc0_reg[g] <= zc0_reg[g] + 2'h1;
      end
      assign ais_cond[g] = ais_reg[g];
      assign c2_uneq[g] = c2_label[8*g +: 8] == `SLAM_C2_UNEQ;
      // Summary of seven conditions, with RDI, LOP, OOF
      assign alarm_any[g] = ais_cond[g] | line_rdi[g] | path_ais[g] | path_rdi[g]
                          | c2_uneq[g] | lop[g] | oof[g];
      slam_lcd u_lcd
      (
        .pclk    (pclk),
        .presetn (presetn),
        .ocd     (ocd[g]),
        .lcd     (lcd[g])
      );
      slam_ind u_fr
      (
        .pclk (pclk), .presetn (presetn), .cond (oof[g]), .hist_clr (hist_clr), .ind (fr_ind[g])
      );
      slam_ind u_cs
      (
        .pclk (pclk), .presetn (presetn), .cond (lcd[g]), .hist_clr (hist_clr), .ind (cs_ind[g])
      );
      slam_ind u_al
      (
        .pclk (pclk), .presetn (presetn), .cond (alarm_any[g]), .hist_clr (hist_clr), .ind (al_ind[g])
      );
    end
  endgenerate

  wire [8:0] util_sum = {1'b0, util_reg[7:0]} + {1'b0, util_reg[15:8]};
  wire       slicing  = util_sum > 9'(`SLAM_SLICE_PCT);

  slam_ind u_sl
  (
    .pclk (pclk), .presetn (presetn), .cond (slicing), .hist_clr (hist_clr), .ind (sl_ind)
  );

  // Datapath selection
  wire       loop_on  = ctrl_reg[`SLAM_CTRL_LOOP];
  wire       scram_on = ctrl_reg[`SLAM_CTRL_SCRAM];
  // Loopback feeds second receiver from first transmitter
  wire [7:0] rx2_src  = loop_on ? first_transmitter_data : second_receiver_data;
  logic [6:0] lfsr_reg;   // Simple payload scrambler state
  wire [7:0] scr_mask = {lfsr_reg, lfsr_reg[6] ^ lfsr_reg[5]};
  wire [7:0] rx1_v = scram_on ? first_receiver_data ^ scr_mask : first_receiver_data;
  wire [7:0] rx2_v = scram_on ? rx2_src ^ scr_mask : rx2_src;
  // Idle/unassigned discard on the selected port only
  wire [1:0] port_hit = ctrl_reg[`SLAM_CTRL_PORTSEL] ? 2'b10 : 2'b01;
  wire [1:0] drop_idle = {2{ctrl_reg[`SLAM_CTRL_FILTER]}} & port_hit & cell_idle;

  // Registered datapath outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_receiver_out  <= 8'h00;
      second_receiver_out <= 8'h00;
      cell_pass           <= 2'b00;
      byte_drop           <= 1'b0;
      lfsr_reg            <= 7'h7f;
    end
    else
    begin
      first_receiver_out  <= rx1_v;
      second_receiver_out <= rx2_v;
      cell_pass           <= cell_valid & ~drop_idle;
      byte_drop           <= slicing & payload_byte;
      lfsr_reg            <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
    end
  end

  // Event pulses: rising active conditions
  logic [9:0] ev_prev_reg;
  wire  [9:0] ev_lvl = {slicing, 1'b0, alarm_any, lcd, oof, ais_cond};
  wire  [9:0] ev_set = ev_lvl & ~ev_prev_reg;
  wire  [9:0] ev_clr = (wr_ok & hit_is) ? pwdata[9:0] : 10'h000;

  // Registers and bus answers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg     <= `SLAM_CTRL_RST;
      util_reg     <= 16'h0000;
      irq_mask_reg <= 10'h000;
      irq_stat_reg <= 10'h000;
      ev_prev_reg  <= 10'h000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      prdata_reg   <= 32'h00000000;
      led_state    <= 14'h0000;
      irq          <= 1'b0;
    end
    else
    begin
      ev_prev_reg  <= ev_lvl;
      // Set wins over a write-one clear
      irq_stat_reg <= (irq_stat_reg & ~ev_clr) | ev_set;
      irq          <= |(irq_stat_reg & irq_mask_reg);
      led_state    <= {sl_ind, al_ind[1], al_ind[0], cs_ind[1], cs_ind[0], fr_ind[1], fr_ind[0]};
      if (wr_ok && hit_ctl)
        ctrl_reg <= {pwdata[4], 1'b0, pwdata[2:0]};
      if (wr_ok && hit_ut)
        util_reg <= pwdata[15:0];
      if (wr_ok && hit_im)
        irq_mask_reg <= pwdata[9:0];
      // No wait state: answer in the access cycle after setup
      pready_reg  <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite)
        prdata_reg <= hit_ctl ? {27'h0, ctrl_reg} :
                      hit_st  ? {22'h0, lcd, oof, alarm_any, ais_cond, slicing, ctrl_reg[`SLAM_CTRL_LOOP]} :
                      hit_is  ? {22'h0, irq_stat_reg} :
                      hit_im  ? {22'h0, irq_mask_reg} :
                      hit_ut  ? {16'h0, util_reg} :
                      hit_led ? {18'h0, led_state} : 32'h00000000;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  sequence s_oof_up(i); $rose(oof[i]); endsequence
  chk_frame_red : assert property (@(posedge pclk) disable iff (!presetn)
    s_oof_up(0) |=> led_state[1:0] == SLAM_ACTIVE) else $error("Frame red missing");
  chk_alarm_sum : assert property (@(posedge pclk) disable iff (!presetn)
    lop[0] |=> led_state[9:8] == SLAM_ACTIVE) else $error("Pointer loss not in alarm");
  chk_c2_alarm : assert property (@(posedge pclk) disable iff (!presetn)
    c2_uneq[0] |=> led_state[9:8] == SLAM_ACTIVE) else $error("C2 alarm missing");
  chk_slice_drop : assert property (@(posedge pclk) disable iff (!presetn)
    slicing && payload_byte |=> byte_drop) else $error("No byte drop while slicing");
  chk_hist_clear : assert property (@(posedge pclk) disable iff (!presetn)
    restart && !oof[0] ##1 !oof[0] |=> led_state[1:0] == SLAM_CLEAN) else $error("History kept");
  chk_loop_path : assert property (@(posedge pclk) disable iff (!presetn)
    loop_on && !scram_on |=> second_receiver_out == $past(first_transmitter_data)) else $error("Loop");
  chk_idle_drop : assert property (@(posedge pclk) disable iff (!presetn)
    drop_idle[0] |=> !cell_pass[0]) else $error("Idle cell passed");
  chk_irq_level : assert property (@(posedge pclk) disable iff (!presetn)
    |(irq_stat_reg & irq_mask_reg) |=> irq) else $error("Irq missing");
endmodule : slam_monitor

// File: slam_pkg.sv
package slam_pkg;
  // Three-colour indication
  typedef enum logic [1:0]
  {
    SLAM_CLEAN   = 2'b00,
    SLAM_HISTORY = 2'b01,
    SLAM_ACTIVE  = 2'b11
  } slam_ind_e;
endpackage : slam_pkg

// File: sonet_line_alarm_status_monitor_tb_top.sv
`timescale 1ns/1ps
module sonet_line_alarm_status_monitor_tb_top;
  import slam_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, restart, payload_byte;
  logic        pready, pslverr, byte_drop, irq, ones, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0]  oof, ocd, line_rdi, path_ais, path_rdi, lop, frame_end, zero_seen;
  logic [1:0]  cell_valid, cell_idle, cell_pass;
  logic [15:0] c2_label;
  logic [7:0]  first_receiver_data, second_receiver_data, first_transmitter_data;
  logic [7:0]  first_receiver_out, second_receiver_out;
  logic [13:0] led_state;
  logic [6:0]  fault;
  int          err_count, comparisons, cycles;

  slam_monitor u_slam_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .restart, .oof, .ocd, .line_rdi, .path_ais, .path_rdi, .lop,
    .c2_label, .frame_end, .zero_seen, .cell_valid, .cell_idle, .first_receiver_data,
    .second_receiver_data, .first_transmitter_data, .payload_byte, .first_receiver_out,
    .second_receiver_out, .cell_pass, .byte_drop, .led_state, .irq);
  slam_line_model u_slam_line_model (.pclk, .presetn, .fault, .ones, .oof, .ocd, .line_rdi,
    .path_ais, .path_rdi, .lop, .c2_label, .frame_end, .zero_seen);

  // 20 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Hang guard, well above the 80000-cycle delineation wait
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  // One APB transfer; entered just after an edge, holds until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No assumed latency: only the bench timeout ends this wait
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never reassigns psel in one step
    @(posedge pclk);
  endtask : apb

  initial
  begin
    {psel, penable, pwrite, restart, payload_byte, ones} = '0;
    {paddr, pwdata, fault, cell_valid, cell_idle} = '0;
    {first_receiver_data, second_receiver_data, first_transmitter_data} = '0;
    presetn = 1'b0;
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
    apb(0, 12'h000, 0); chk(r, 0);
    apb(0, 12'h014, 0); chk(r, 0);
    apb(0, 12'h0f0, 0); chk({31'h0, e}, 1);
    // Frame sync colours, rx2 untouched
    fault <= 7'h01; cyc(4); chk(led_state[3:0], 4'h3);
    fault <= 7'h00; cyc(4); chk(led_state[1:0], 2'h1);
    restart <= 1'b1; cyc(1); restart <= 1'b0; cyc(3); chk(led_state[1:0], 0);
    // Each fault-driven alarm source (all but AIS), skipping cell delineation
    for (int i = 0; i < 7; i++)
      if (i != 1)
      begin
        fault <= 7'h01 << i; cyc(4); chk(led_state[9:8], 2'h3);
        apb(1, 12'h000, 8); cyc(3); chk(led_state[9:8], 2'h3);
        fault <= 0; cyc(4); chk(led_state[9:8], 2'h1);
        apb(1, 12'h000, 8); cyc(3); chk(led_state[9:8], 0);
      end
    // All-ones line while out of frame
    ones <= 1'b1; fault <= 7'h01; cyc(24);
    apb(0, 12'h004, 0); chk(r & 4, 4);
    ones <= 1'b0; fault <= 0;
    // Slicing at the 114 percent boundary, with its interrupt
    payload_byte <= 1'b1;
    apb(1, 12'h00c, 32'h200); apb(1, 12'h010, 32'h3939); cyc(3);
    chk({led_state[13:12], irq, byte_drop}, 0);
    apb(1, 12'h010, 32'h3a39); cyc(3); chk({led_state[13:12], irq, byte_drop}, 4'hf);
    apb(1, 12'h010, 0); cyc(3); chk(led_state[13:12], 1);
    apb(0, 12'h008, 0); chk(r & 32'h200, 32'h200);
    apb(1, 12'h008, 32'h200); cyc(2); chk(irq, 0);
    // Cell delineation must stay lost 80000 cycles
    fault <= 7'h02; cyc(79980); chk(led_state[5:4], 0);
    cyc(30); chk(led_state[5:4], 2'h3);
    fault <= 0; cyc(4); chk(led_state[5:4], 2'h1);
    // Idle filter on rx1
    apb(1, 12'h000, 1); cell_valid <= 2'h1; cell_idle <= 2'h1; cyc(3);
    chk(cell_pass[0], 0);
    // Filter aimed at rx2 leaves rx1 idle cells alone
    apb(1, 12'h000, 32'h11); cyc(3); chk(cell_pass[0], 1);
    cell_idle <= 0; cyc(3); chk(cell_pass[0], 1);
    // Loopback and unscrambled path
    apb(1, 12'h000, 4); first_transmitter_data <= 8'ha5;
    second_receiver_data <= 8'h3c; first_receiver_data <= 8'h96; cyc(3);
    chk(second_receiver_out, 8'ha5);
    chk(first_receiver_out, 8'h96);
    // Scrambler on: a non-zero mask must alter the byte
    apb(1, 12'h000, 6); cyc(2); chk({31'h0, first_receiver_out != 8'h96}, 1);
    // Mid-run reset returns every indication to clean
    presetn <= 1'b0; cyc(2); chk({led_state, irq, byte_drop, cell_pass}, 0);
    presetn <= 1'b1; cyc(1); apb(0, 12'h000, 0); chk(r, 0);
    report_and_stop();
  end
endmodule : sonet_line_alarm_status_monitor_tb_top
